//--- bfpc_top.sv
// control pin sequencer: shutdown, standby, address select and boot fallback
`default_nettype none
// How it works
// [RULE1] shutdown pin high clears every register
// [RULE2] after shutdown, full reset and load again
// [RULE3] default standby stops clocks, analog, ramps volume
// [RULE4] standby keeps register contents
// [RULE5] failed boot plus standby low: power down
// [RULE6] after good boot firmware owns standby
// [RULE7] per-pair converter power-down registers
// [RULE8] reference off only with all converters off
// [RULE9] address select picks slave and master address
// [RULE10] general pins sampled as levels
// [RULE11] handshake pin is input at power-up
// [RULE12] failed boot: pin high mutes DACs
// [RULE13] good boot drives handshake pin low
// [RULE14] pins three, four select serial inputs
// [RULE15] failed boot pin high: defaults, outputs quiet
// [RULE16] status and slave first, then pin low
// [RULE17] read error recorded in status at 0x02
// [RULE18] controller waits for pin falling edge
// [RULE19] failed boot pin low: serial passthrough
// [RULE20] no memory: done about 100 ms after reset
// [RULE21] after programming pins are in, out or both
// [RULE22] no memory or error: master off, slave on
// [RULE23] master and slave never both enabled
// [RULE24] pin inputs pass two-stage synchroniser
module bfpc_top #(
  parameter int LOAD_CYCLES = bfpc_pkg::LOAD_CYCLES,
  parameter int NUM_GP      = 4
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic              i_regulator_shutdown,
  input  wire logic              i_standby_pin,
  input  wire logic              i_bus_address_select,
  input  wire logic [NUM_GP-1:0] i_gp_pin,
  input  wire logic              i_boot_done,
  input  wire logic              i_boot_ok,
  input  wire logic              i_boot_no_mem,
  input  wire logic              i_boot_read_err,
  input  wire logic              i_fw_standby_en,
  input  wire logic              i_fw_standby_req,
  input  wire logic [NUM_GP-1:0] i_fw_gp_oe,
  input  wire logic [NUM_GP-1:0] i_fw_gp_out,
  input  wire logic [1:0]        i_fw_sdin_sel,
  input  wire logic              i_slave_wr,
  input  wire logic [7:0]        i_slave_sub,
  input  wire logic [7:0]        i_slave_wdata,
  input  wire logic              i_serial_audio_in_one,
  input  wire logic              i_serial_audio_in_two,
  output logic [NUM_GP-1:0]      o_gp_out,
  output logic [NUM_GP-1:0]      o_gp_oe,
  output logic [NUM_GP-1:0]      o_gp_in_level,
  output logic                   o_serial_audio_out_one,
  output logic                   o_serial_audio_out_two,
  output logic                   o_sdout_active,
  output logic                   o_passthrough,
  output logic                   o_dac_enable,
  output logic                   o_regulators_on,
  output logic                   o_clocks_run,
  output logic                   o_analog_on,
  output logic                   o_volume_ramp_down,
  output logic                   o_master_en,
  output logic                   o_slave_en,
  output logic [6:0]             o_slave_addr,
  output logic [6:0]             o_master_addr,
  output logic [3:0]             o_dac_pd,
  output logic [3:0]             o_adc_pd,
  output logic                   o_ref_pd,
  output logic                   o_ref_pd_rejected,
  output logic [31:0]            o_boot_load_status
);
  localparam int NSYNC = NUM_GP + 3;
  localparam int CW    = $clog2(LOAD_CYCLES + 1);
  localparam logic [7:0] SUB_DAC_PD = 8'h40;
  localparam logic [7:0] SUB_ADC_PD = 8'h41;
  localparam logic [7:0] SUB_REF_PD = 8'h42;

  ////////////////////////////////////////////////////////////////////////////
  // [RULE24] two-stage synchroniser
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  always_ff @(posedge i_clk) begin
    sync1_reg <= {i_gp_pin, i_bus_address_select, i_standby_pin, i_regulator_shutdown};
    sync2_reg <= sync1_reg;
  end
  logic              s_shut;
  logic              s_stby;
  logic              s_cs;
  logic [NUM_GP-1:0] s_gp;
  assign s_shut = sync2_reg[0];
  assign s_stby = sync2_reg[1];
  assign s_cs   = sync2_reg[2];
  // [RULE10] level sampled pins
  assign s_gp   = sync2_reg[NSYNC-1:3];

  ////////////////////////////////////////////////////////////////////////////
  // sequencer state
  bfpc_pkg::bfpc_state_t state_reg, state_next;
  logic [CW-1:0]  cnt_reg, cnt_next;
  logic [31:0]    status_reg, status_next;
  logic           test_reg, test_next;
  logic           mute_reg, mute_next;
  logic [3:0]     dac_pd_reg, dac_pd_next;
  logic [3:0]     adc_pd_reg, adc_pd_next;
  logic           ref_pd_reg, ref_pd_next;
  logic           rej_reg, rej_next;
  logic           cs_reg, cs_next;

  always_comb begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    status_next = status_reg;
    test_next   = test_reg;
    mute_next   = mute_reg;
    dac_pd_next = dac_pd_reg;
    adc_pd_next = adc_pd_reg;
    ref_pd_next = ref_pd_reg;
    rej_next    = 1'b0;
    cs_next     = cs_reg;
    case (state_reg)
      bfpc_pkg::BFPC_OFF: begin
        // [RULE2] leave shutdown only through init
        if (!s_shut) begin
          state_next = bfpc_pkg::BFPC_INIT;
          cnt_next   = '0;
        end
      end
      bfpc_pkg::BFPC_INIT: begin
        cnt_next = cnt_reg + CW'(1);
        if (cnt_reg == CW'(bfpc_pkg::INIT_CYCLES)) begin
          // address strap caught once init is over
          cs_next    = s_cs;
          state_next = bfpc_pkg::BFPC_BOOT;
          cnt_next   = '0;
        end
      end
      bfpc_pkg::BFPC_BOOT: begin
        if (cnt_reg != CW'(LOAD_CYCLES)) begin
          cnt_next = cnt_reg + CW'(1);
        end
        if (i_boot_done && i_boot_ok) begin
          status_next[bfpc_pkg::STATUS_BOOT_OK_BIT] = 1'b1;
          status_next[bfpc_pkg::STATUS_DONE_BIT]    = 1'b1;
          state_next = bfpc_pkg::BFPC_RUN_OK;
        end else if (i_boot_done) begin
          // [RULE22] no memory or read error falls back
          status_next[bfpc_pkg::STATUS_NO_MEM_BIT]   = i_boot_no_mem;
          // [RULE17] read error kept in status
          status_next[bfpc_pkg::STATUS_READ_ERR_BIT] = i_boot_read_err;
          // [RULE15] [RULE19] mode from handshake pin level
          test_next  = !s_gp[0];
          // [RULE12] pin high mutes DACs
          mute_next  = s_gp[0];
          state_next = bfpc_pkg::BFPC_FB_WAIT;
        end
      end
      bfpc_pkg::BFPC_FB_WAIT: begin
        // [RULE20] no-memory load completes at the 100 ms mark
        if (cnt_reg != CW'(LOAD_CYCLES)) begin
          cnt_next = cnt_reg + CW'(1);
        end else begin
          status_next[bfpc_pkg::STATUS_DONE_BIT] = 1'b1;
          status_next[bfpc_pkg::STATUS_TEST_BIT] = test_reg;
          state_next = bfpc_pkg::BFPC_FB_SLAVE;
        end
      end
      // [RULE16] status and slave one cycle ahead of pin
      bfpc_pkg::BFPC_FB_SLAVE: state_next = bfpc_pkg::BFPC_RUN_FB;
      bfpc_pkg::BFPC_RUN_FB,
      bfpc_pkg::BFPC_RUN_OK: begin
        // [RULE7] converter power-down over slave port
        if (i_slave_wr && i_slave_sub == SUB_DAC_PD) begin
          dac_pd_next = i_slave_wdata[3:0];
        end
        if (i_slave_wr && i_slave_sub == SUB_ADC_PD) begin
          adc_pd_next = i_slave_wdata[3:0];
        end
        if (i_slave_wr && i_slave_sub == SUB_REF_PD) begin
          // [RULE8] reference off needs every converter off
          if (i_slave_wdata[0] && (dac_pd_reg != bfpc_pkg::PD_ALL_OFF ||
                                   adc_pd_reg != bfpc_pkg::PD_ALL_OFF)) begin
            rej_next = 1'b1;
          end else begin
            ref_pd_next = i_slave_wdata[0];
          end
        end
        // converters may not wake under a downed reference
        if (ref_pd_reg && (dac_pd_next != bfpc_pkg::PD_ALL_OFF ||
                           adc_pd_next != bfpc_pkg::PD_ALL_OFF)) begin
          dac_pd_next = dac_pd_reg;
          adc_pd_next = adc_pd_reg;
          rej_next    = 1'b1;
        end
      end
      default: state_next = bfpc_pkg::BFPC_OFF;
    endcase
    // [RULE1] shutdown drops every setting
    if (s_shut) begin
      state_next  = bfpc_pkg::BFPC_OFF;
      cnt_next    = '0;
      status_next = bfpc_pkg::STATUS_RESET;
      test_next   = 1'b0;
      mute_next   = 1'b0;
      dac_pd_next = bfpc_pkg::PD_ALL_ON;
      adc_pd_next = bfpc_pkg::PD_ALL_ON;
      ref_pd_next = 1'b0;
      cs_next     = 1'b0;
    end
  end

  // [RULE4] standby never touches this state
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg  <= bfpc_pkg::BFPC_OFF;
      cnt_reg    <= '0;
      status_reg <= bfpc_pkg::STATUS_RESET;
      test_reg   <= 1'b0;
      mute_reg   <= 1'b0;
      dac_pd_reg <= bfpc_pkg::PD_ALL_ON;
      adc_pd_reg <= bfpc_pkg::PD_ALL_ON;
      ref_pd_reg <= 1'b0;
      rej_reg    <= 1'b0;
      cs_reg     <= 1'b0;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      status_reg <= status_next;
      test_reg   <= test_next;
      mute_reg   <= mute_next;
      dac_pd_reg <= dac_pd_next;
      adc_pd_reg <= adc_pd_next;
      ref_pd_reg <= ref_pd_next;
      rej_reg    <= rej_next;
      cs_reg     <= cs_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  logic run_ok;
  logic run_fb;
  logic stby;
  assign run_ok = (state_next == bfpc_pkg::BFPC_RUN_OK);
  assign run_fb = (state_next == bfpc_pkg::BFPC_RUN_FB);
  always_comb begin
    // [RULE6] firmware defines standby after good boot
    if (run_ok && i_fw_standby_en) begin
      stby = i_fw_standby_req;
    // [RULE5] failed boot with pin low stays down
    end else if (run_fb || state_next == bfpc_pkg::BFPC_FB_SLAVE) begin
      stby = !s_stby;
    end else begin
      stby = run_ok && !s_stby;
    end
  end

  logic [NUM_GP-1:0] gp_oe_next;
  logic [NUM_GP-1:0] gp_out_next;
  always_comb begin
    // [RULE11] pins start as inputs
    gp_oe_next  = '0;
    gp_out_next = '0;
    if (run_ok) begin
      // [RULE13] [RULE21] firmware owns direction and level from the first good-boot cycle, low drive included
      gp_oe_next  = i_fw_gp_oe;
      gp_out_next = i_fw_gp_out;
      // [RULE14] serial input pins stay inputs
      if (i_fw_sdin_sel[0]) gp_oe_next[2] = 1'b0;
      if (i_fw_sdin_sel[1]) gp_oe_next[3] = 1'b0;
    end else if (run_fb) begin
      // [RULE16] handshake pin driven low last
      gp_oe_next[0] = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_gp_out               <= '0;
      o_gp_oe                <= '0;
      o_gp_in_level          <= '0;
      o_serial_audio_out_one <= 1'b0;
      o_serial_audio_out_two <= 1'b0;
      o_sdout_active         <= 1'b0;
      o_passthrough          <= 1'b0;
      o_dac_enable           <= 1'b0;
      o_regulators_on        <= 1'b0;
      o_clocks_run           <= 1'b0;
      o_analog_on            <= 1'b0;
      o_volume_ramp_down     <= 1'b0;
      o_master_en            <= 1'b0;
      o_slave_en             <= 1'b0;
      o_slave_addr           <= bfpc_pkg::SLAVE_ADDR_BASE;
      o_master_addr          <= bfpc_pkg::MASTER_ADDR_BASE;
      o_dac_pd               <= bfpc_pkg::PD_ALL_ON;
      o_adc_pd               <= bfpc_pkg::PD_ALL_ON;
      o_ref_pd               <= 1'b0;
      o_ref_pd_rejected      <= 1'b0;
      o_boot_load_status     <= bfpc_pkg::STATUS_RESET;
    end else begin
      o_gp_out               <= gp_out_next;
      o_gp_oe                <= gp_oe_next;
      o_gp_in_level          <= s_gp;
      // [RULE19] test mode streams serial in to out
      o_serial_audio_out_one <= run_fb && test_reg && !stby && i_serial_audio_in_one;
      o_serial_audio_out_two <= run_fb && test_reg && !stby && i_serial_audio_in_two;
      // [RULE15] default mode keeps outputs quiet
      o_sdout_active         <= (run_fb && test_reg && !stby) || (run_ok && !stby);
      o_passthrough          <= run_fb && test_reg;
      o_dac_enable           <= (run_fb && !mute_reg && !stby) || (run_ok && !stby);
      o_regulators_on        <= state_next != bfpc_pkg::BFPC_OFF;
      // [RULE3] standby stops clocks, analog, ramps volume
      o_clocks_run           <= state_next != bfpc_pkg::BFPC_OFF && !stby;
      o_analog_on            <= (run_fb || run_ok) && !stby;
      o_volume_ramp_down     <= stby;
      // [RULE23] master only while booting, slave only after
      o_master_en            <= state_next == bfpc_pkg::BFPC_BOOT;
      o_slave_en             <= run_ok || run_fb || state_next == bfpc_pkg::BFPC_FB_SLAVE;
      // [RULE9] address select sets low address bit
      o_slave_addr           <= bfpc_pkg::SLAVE_ADDR_BASE | {6'h00, cs_next};
      o_master_addr          <= bfpc_pkg::MASTER_ADDR_BASE | {6'h00, cs_next};
      o_dac_pd               <= dac_pd_next;
      o_adc_pd               <= adc_pd_next;
      o_ref_pd               <= ref_pd_next;
      o_ref_pd_rejected      <= rej_next;
      // [RULE17] status visible at subaddress 0x02
      o_boot_load_status     <= status_next;
    end
  end
endmodule
`default_nettype wire

//--- bfpc_pkg.sv
// constants shared by the boot fallback and power pin controller
`default_nettype none
package bfpc_pkg;
  localparam logic [7:0]  BOOT_LOAD_STATUS_OFS = 8'h02;
  localparam logic [6:0]  SLAVE_ADDR_BASE      = 7'h34;
  localparam logic [6:0]  MASTER_ADDR_BASE     = 7'h50;
  localparam int          CLK_HZ               = 20000000;
  localparam int          LOAD_TIME_MS         = 100;
  localparam int          LOAD_CYCLES          = LOAD_TIME_MS * (CLK_HZ / 1000);
  localparam int          INIT_CYCLES          = 16;
  localparam int          STATUS_NO_MEM_BIT    = 0;
  localparam int          STATUS_READ_ERR_BIT  = 1;
  localparam int          STATUS_DONE_BIT      = 2;
  localparam int          STATUS_TEST_BIT      = 3;
  localparam int          STATUS_BOOT_OK_BIT   = 4;
  localparam logic [31:0] STATUS_RESET         = 32'h0000_0000;
  localparam logic [3:0]  PD_ALL_ON            = 4'h0;
  localparam logic [3:0]  PD_ALL_OFF           = 4'hF;
  typedef enum logic [2:0] {
    BFPC_OFF      = 3'b000,
    BFPC_INIT     = 3'b001,
    BFPC_BOOT     = 3'b010,
    BFPC_FB_WAIT  = 3'b011,
    BFPC_FB_SLAVE = 3'b100,
    BFPC_RUN_FB   = 3'b101,
    BFPC_RUN_OK   = 3'b110
  } bfpc_state_t;
endpackage
`default_nettype wire

//--- bfpc_assertions.sv
// concurrent checks on the control pin sequencer ports
`default_nettype none
module bfpc_checker #(
  parameter int NUM_GP = 4
) (
  input wire logic              i_clk,
  input wire logic              i_rst,
  input wire logic              i_regulator_shutdown,
  input wire logic [NUM_GP-1:0] o_gp_out,
  input wire logic [NUM_GP-1:0] o_gp_oe,
  input wire logic              o_sdout_active,
  input wire logic              o_passthrough,
  input wire logic              o_dac_enable,
  input wire logic              o_regulators_on,
  input wire logic              o_master_en,
  input wire logic              o_slave_en,
  input wire logic [6:0]        o_slave_addr,
  input wire logic [6:0]        o_master_addr,
  input wire logic [3:0]        o_dac_pd,
  input wire logic [3:0]        o_adc_pd,
  input wire logic              o_ref_pd,
  input wire logic              o_ref_pd_rejected,
  input wire logic [31:0]       o_boot_load_status
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_bus_exclusive: assert property (!(o_master_en && o_slave_en))
    else $error("master and slave bus enabled together");
  a_fb_handoff: assert property (
    $rose(o_boot_load_status[2]) && !o_boot_load_status[4] |->
    o_slave_en && !o_master_en && !o_gp_oe[0] ##1 o_gp_oe[0] && !o_gp_out[0])
    else $error("fallback handoff order wrong");
  a_mute_high: assert property (
    o_boot_load_status[2] && !o_boot_load_status[3] && !o_boot_load_status[4]
    |-> !o_dac_enable && !o_sdout_active)
    else $error("muted fallback left outputs on");
  // streaming starts one cycle after the status update, and stops with it on shutdown
  a_test_pass: assert property (
    $past(o_boot_load_status[3]) && o_boot_load_status[3] |-> o_passthrough)
    else $error("test fallback without passthrough");
  a_shutdown_clears: assert property (
    i_regulator_shutdown [*4] |-> !o_regulators_on && !o_slave_en
    && o_boot_load_status == 32'h0000_0000)
    else $error("shutdown kept state");
  a_ref_guard: assert property (
    $rose(o_ref_pd) |-> $past(o_dac_pd) == 4'hF && $past(o_adc_pd) == 4'hF)
    else $error("reference down with converters on");
  a_reject_hold: assert property (
    o_ref_pd_rejected |-> $stable(o_ref_pd) ##1 !o_ref_pd_rejected)
    else $error("rejected request changed reference");
  a_addr_select: assert property (
    o_slave_addr[6:1] == bfpc_pkg::SLAVE_ADDR_BASE[6:1] &&
    o_master_addr[6:1] == bfpc_pkg::MASTER_ADDR_BASE[6:1] &&
    o_slave_addr[0] == o_master_addr[0])
    else $error("bus address wrong");
endmodule
`default_nettype wire

//--- bfpc_board_model.sv
// board controller model: handshake pin pull and falling edge watch
`default_nettype none
module bfpc_board_model (
  input  wire logic i_clk,
  input  wire logic i_clear,
  input  wire logic i_pull_level,
  input  wire logic i_pin_oe,
  input  wire logic i_pin_out,
  output logic      o_pin_level,
  output logic      o_status_read_ok
);
  timeunit 1ns;
  timeprecision 1ns;
  logic level_reg;
  // pin is a level: device drive wins over board pull
  assign o_pin_level = i_pin_oe ? i_pin_out : i_pull_level;
  // status read allowed only after high-to-low
  always @(posedge i_clk) begin
    level_reg <= o_pin_level;
    if (i_clear) begin
      o_status_read_ok <= 1'b0;
    end else if (level_reg && !o_pin_level) begin
      o_status_read_ok <= 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- tb_top.sv
// self-checking bench for the control pin sequencer
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LC = 50;
  logic        clk, rst, shd, stby, cs, done, ok, nomem, rderr, fwen, fwreq;
  logic        wr, sin1, sin2, pull, clr, pin0, seen, so1, so2, sda, pth, dac;
  logic        reg_on, crun, ana, vol, men, sen, rpd, rej;
  logic [3:0]  fwoe, fwout, goe, gout, gin, dpd, apd;
  logic [2:0]  ghi;
  logic [1:0]  sel;
  logic [7:0]  sub, wd;
  logic [6:0]  sadr, madr;
  logic [31:0] st;
  int          bad_count, samples_checked, n, cyc;
  bfpc_top #(.LOAD_CYCLES(LC)) dut (.i_clk(clk), .i_rst(rst), .i_regulator_shutdown(shd),
    .i_standby_pin(stby), .i_bus_address_select(cs), .i_gp_pin({ghi, pin0}),
    .i_boot_done(done), .i_boot_ok(ok), .i_boot_no_mem(nomem), .i_boot_read_err(rderr),
    .i_fw_standby_en(fwen), .i_fw_standby_req(fwreq), .i_fw_gp_oe(fwoe), .i_fw_gp_out(fwout),
    .i_fw_sdin_sel(sel), .i_slave_wr(wr), .i_slave_sub(sub), .i_slave_wdata(wd),
    .i_serial_audio_in_one(sin1), .i_serial_audio_in_two(sin2), .o_gp_out(gout),
    .o_gp_oe(goe), .o_gp_in_level(gin), .o_serial_audio_out_one(so1),
    .o_serial_audio_out_two(so2), .o_sdout_active(sda), .o_passthrough(pth),
    .o_dac_enable(dac), .o_regulators_on(reg_on), .o_clocks_run(crun), .o_analog_on(ana),
    .o_volume_ramp_down(vol), .o_master_en(men), .o_slave_en(sen), .o_slave_addr(sadr),
    .o_master_addr(madr), .o_dac_pd(dpd), .o_adc_pd(apd), .o_ref_pd(rpd),
    .o_ref_pd_rejected(rej), .o_boot_load_status(st));
  bfpc_board_model u_board (.i_clk(clk), .i_clear(clr), .i_pull_level(pull),
    .i_pin_oe(goe[0]), .i_pin_out(gout[0]), .o_pin_level(pin0), .o_status_read_ok(seen));
  task automatic chk(input logic [31:0] v, input logic [31:0] e);
    samples_checked++;
    if (v !== e) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, v, e);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic step(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic wr_sub(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    sub <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic power_up(input logic p);
    @(posedge clk);
    rst <= 1'b1;
    pull <= p;
    cs <= p;
    clr <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    clr <= 1'b0;
    for (n = 0; n < 60 && men !== 1'b1; n++) step(1);
    chk(men, 1'b1);
    chk(goe[0], 1'b0);
  endtask
  task automatic boot(input logic good, input logic no_mem);
    @(posedge clk);
    done <= 1'b1;
    ok <= good;
    nomem <= no_mem;
    rderr <= !good && !no_mem;
    @(posedge clk);
    done <= 1'b0;
    step(3);
  endtask
  task automatic t_fb_mute();
    power_up(1'b1);
    boot(1'b0, 1'b1);
    chk(dac, 1'b0);
    for (n = 0; n < LC + 20 && sen !== 1'b1; n++) step(1);
    chk({sen, men, goe[0]}, 3'b100);
    chk(n, LC - 4);
    chk(st[4:0], 5'h05);
    step(1);
    chk({goe[0], gout[0]}, 2'b10);
    step(2);
    chk({seen, sda}, 2'b10);
    chk({sadr, madr}, {7'h35, 7'h51});
    @(posedge clk);
    stby <= 1'b0;
    step(6);
    chk({crun, ana, vol}, 3'b001);
    chk(st[4:0], 5'h05);
    @(posedge clk);
    stby <= 1'b1;
    step(6);
    chk(crun, 1'b1);
    wr_sub(8'h42, 8'h01);
    chk({rej, rpd}, 2'b10);
    wr_sub(8'h40, 8'h0F);
    wr_sub(8'h41, 8'h0F);
    chk({dpd, apd}, 8'hFF);
    wr_sub(8'h42, 8'h01);
    chk({rej, rpd}, 2'b01);
    wr_sub(8'h40, 8'h00);
    chk({rej, dpd}, 5'h1F);
    $display("test fallback mute finished");
  endtask
  task automatic t_fb_test();
    power_up(1'b0);
    boot(1'b0, 1'b0);
    for (n = 0; n < LC + 20 && sen !== 1'b1; n++) step(1);
    chk(st[4:0], 5'h0E);
    step(1);
    chk({pth, dac, sda}, 3'b111);
    chk(sadr, 7'h34);
    @(posedge clk);
    sin1 <= 1'b1;
    ghi <= 3'b101;
    step(4);
    chk({so1, so2}, 2'b10);
    chk(gin[3:1], 3'b101);
    @(posedge clk);
    sin1 <= 1'b0;
    sin2 <= 1'b1;
    step(4);
    chk({so1, so2}, 2'b01);
    $display("test fallback passthrough finished");
  endtask
  task automatic t_good();
    power_up(1'b1);
    boot(1'b1, 1'b0);
    chk({goe[0], gout[0], men}, 3'b100);
    @(posedge clk);
    fwoe <= 4'hF;
    fwout <= 4'hA;
    sel <= 2'b11;
    fwen <= 1'b1;
    stby <= 1'b0;
    step(6);
    chk({goe, gout[1:0]}, 6'h0E);
    chk(crun, 1'b1);
    @(posedge clk);
    fwreq <= 1'b1;
    step(4);
    chk(crun, 1'b0);
    @(posedge clk);
    shd <= 1'b1;
    step(6);
    chk(reg_on, 1'b0);
    chk(st, 32'h0);
    @(posedge clk);
    shd <= 1'b0;
    for (n = 0; n < 60 && men !== 1'b1; n++) step(1);
    chk(men, 1'b1);
    chk(st, 32'h0);
    $display("test good boot and shutdown finished");
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    {rst, shd, stby, cs, done, ok, nomem, rderr, fwen, fwreq} = 10'h280;
    {wr, sin1, sin2, pull, clr, ghi, sel, fwoe, fwout, sub, wd} = '0;
    {bad_count, samples_checked, cyc} = '0;
    fwoe = 4'h1;
    t_fb_mute();
    t_fb_test();
    t_good();
    summarize();
  end
endmodule
bind bfpc_top bfpc_checker #(.NUM_GP(NUM_GP)) u_chk (.i_clk(i_clk), .i_rst(i_rst),
  .i_regulator_shutdown(i_regulator_shutdown), .o_gp_out(o_gp_out), .o_gp_oe(o_gp_oe),
  .o_sdout_active(o_sdout_active), .o_passthrough(o_passthrough),
  .o_dac_enable(o_dac_enable), .o_regulators_on(o_regulators_on),
  .o_master_en(o_master_en), .o_slave_en(o_slave_en), .o_slave_addr(o_slave_addr),
  .o_master_addr(o_master_addr), .o_dac_pd(o_dac_pd), .o_adc_pd(o_adc_pd),
  .o_ref_pd(o_ref_pd), .o_ref_pd_rejected(o_ref_pd_rejected),
  .o_boot_load_status(o_boot_load_status));
`default_nettype wire
